// ---- logic/fpmp_pkg.sv ----
// fpmp_pkg: command codes, status byte layout, strap value and state codes
// for the programmer-mode parallel port; shared by the port logic, its checker and the testbench.
package fpmp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command bytes, first and second cycle
  localparam logic [7:0] FPMP_CMD_READ    = 8'h00;
  localparam logic [7:0] FPMP_CMD_PROGRAM = 8'h40;
  localparam logic [7:0] FPMP_CMD_ERASE   = 8'h20;
  localparam logic [7:0] FPMP_CMD_STATUS  = 8'h71;

  // legal low address bytes for a program page start
  localparam logic [7:0] FPMP_PAGE_LOW_A  = 8'h00;
  localparam logic [7:0] FPMP_PAGE_LOW_B  = 8'h80;

  // strap that selects the doubling pll
  localparam logic [3:0] FPMP_STRAP_PLLX2 = 4'hd;

  // documented geometry
  localparam int FPMP_ADDR_W     = 18;
  localparam int FPMP_PAGE_BYTES = 128;

  ////////////////////////////////////////////////////////////////////////////
  // status byte bit positions
  localparam int FPMP_ST_END_BIT   = 7;  // operation ended
  localparam int FPMP_ST_OK_BIT    = 6;  // normal completion
  localparam int FPMP_ST_ERASE_BIT = 5;  // erase failed in the array
  localparam int FPMP_ST_PGM_BIT   = 4;  // program failed in the array
  localparam int FPMP_ST_ADDR_BIT  = 3;  // page start address not aligned
  localparam int FPMP_ST_PROT_BIT  = 2;  // program enable absent

  // reset values
  localparam logic [7:0] FPMP_DATA_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // port state, one-hot
  typedef enum logic [9:0] {
    FPMP_READ        = 10'h001,
    FPMP_PGM_LOAD    = 10'h002,
    FPMP_PGM_PUSH    = 10'h004,
    FPMP_PGM_WAIT    = 10'h008,
    FPMP_ERASE_ARM   = 10'h010,
    FPMP_ERASE_WAIT  = 10'h020,
    FPMP_STATUS_ARM  = 10'h040,
    FPMP_STATUS      = 10'h080,
    FPMP_POLL        = 10'h100,
    FPMP_SPARE       = 10'h200
  } fpmp_state_t;

endpackage : fpmp_pkg

// ---- logic/fpmp_sync.sv ----
// fpmp_sync: two-flop synchroniser for a bundle of pin levels.
// assumes each bit is a slow level; bits of a bundle may settle a cycle apart.
`timescale 1ns/1ps
`default_nettype none

module fpmp_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule : fpmp_sync

`default_nettype wire

// ---- logic/fpmp_port.sv ----
// fpmp_port: programmer-mode byte port in front of the flash array.
// assumes the array answers reads on flash_rd_data the cycle after the
// address, accepts page bytes by valid/ready and reports one op_done pulse.
//
// What this block does
// - offers memory read, auto program, full-chip erase and status read.
// - flash protect pin read as is, high enabling program together with the program enable pin.
// - chip select, output enable and write strobe decide drive, float or input.
// - chip select high floats the bus and ignores writes; logic keeps running.
// - write 00 enters memory read; each later read returns the byte at its own address.
// - write 40, then 128 address-plus-data writes, 129 cycles in all.
// - the 128 gathered bytes program in one operation; polling shows the end.
// - two writes of 20 erase the whole array; polling shows the end.
// - data bit 6 shows normal completion of program or erase.
// - two writes of 71, then a read returns error detail.
// - status read shows internal result signals, not memory contents.
// - page start low byte must be 00 or 80, else write error flagged.
// - bits 6 and 7 hold until the next command write other than 71 made from read, status or polling state.
`timescale 1ns/1ps
`default_nettype none

module fpmp_port
  import fpmp_pkg::*;
#(
  parameter int ADDR_W     = FPMP_ADDR_W,
  parameter int PAGE_BYTES = FPMP_PAGE_BYTES
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // programmer pins
  input  wire logic              chip_sel_n,
  input  wire logic              out_en_n,
  input  wire logic              wr_strobe_n,
  input  wire logic [ADDR_W-1:0] byte_address_bus,
  input  wire logic [7:0]        byte_data_bus_in,
  output logic      [7:0]        byte_data_bus_out,
  output logic                   byte_data_bus_oe,
  input  wire logic              program_enable_pin,
  input  wire logic              flash_protect_pin,
  input  wire logic [3:0]        mode_select_pins,
  // strap and state flags
  output logic                   strap_ok,
  output logic                   op_busy,
  // array read
  output logic      [ADDR_W-1:0] flash_rd_addr,
  input  wire logic [7:0]        flash_rd_data,
  // array page program
  output logic                   pgm_valid,
  output logic      [ADDR_W-1:0] pgm_addr,
  output logic      [7:0]        pgm_data,
  input  wire logic              pgm_ready,
  output logic                   pgm_commit,
  // array erase and result
  output logic                   erase_start,
  input  wire logic              op_done,
  input  wire logic              op_fail
);

  localparam int IDX_W = $clog2(PAGE_BYTES);
  localparam int SYN_W = 9 + ADDR_W + 8;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(PAGE_BYTES - 1);
  localparam logic [IDX_W-1:0] IDX_ONE  = IDX_W'(1);

  // the page index is spliced under the page base, so it must be a power of two
  if (PAGE_BYTES < 2 || PAGE_BYTES > 256 || (1 << IDX_W) != PAGE_BYTES) begin : g_bad_page
    $error("fpmp_port: PAGE_BYTES must be a power of two from 2 to 256");
  end
  if (ADDR_W <= IDX_W || ADDR_W < 8) begin : g_bad_addr
    $error("fpmp_port: ADDR_W too small for the page");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; strobes idle high so release makes no false edge
  logic [SYN_W-1:0]  syn_q;
  logic              ce_s;
  logic              oe_s;
  logic              we_s;
  logic              pe_s;
  logic              fp_s;
  logic [3:0]        md_s;
  logic [ADDR_W-1:0] addr_s;
  logic [7:0]        data_s;

  fpmp_sync #(
    .W       (SYN_W),
    .RST_VAL ({3'b111, (SYN_W-3)'(0)})
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       ({chip_sel_n, out_en_n, wr_strobe_n, program_enable_pin,
                flash_protect_pin, mode_select_pins, byte_address_bus,
                byte_data_bus_in}),
    .q       (syn_q)
  );

  assign {ce_s, oe_s, we_s, pe_s, fp_s, md_s, addr_s, data_s} = syn_q;

  //////////////////////////////////////////////////////////////////////////////
  // write strobe edge; address and data share the strobe's sample time
  logic we_prev_reg;
  logic wr_evt;
  logic prog_allowed;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) we_prev_reg <= 1'b1;
    else       we_prev_reg <= we_s;
  end

  // write strobe rising with select low and output enable high
  assign wr_evt = we_s & ~we_prev_reg & ~ce_s & oe_s;

  // protect pin taken as is, high means program enabled
  assign prog_allowed = pe_s & fp_s;

  //////////////////////////////////////////////////////////////////////////////
  // first-cycle decode, used from every state that accepts a new command
  function automatic fpmp_state_t cmd_target(input logic [7:0] cmd,
                                             input fpmp_state_t cur);
    fpmp_state_t t;
    t = cur;
    case (cmd)
      FPMP_CMD_READ:    t = FPMP_READ;
      FPMP_CMD_PROGRAM: t = FPMP_PGM_LOAD;
      FPMP_CMD_ERASE:   t = FPMP_ERASE_ARM;
      FPMP_CMD_STATUS:  t = FPMP_STATUS_ARM;
      // unknown byte leaves the mode alone
      default:          t = cur;
    endcase
    return t;
  endfunction : cmd_target

  function automatic logic is_cmd(input logic [7:0] cmd);
    return (cmd == FPMP_CMD_READ) || (cmd == FPMP_CMD_PROGRAM) ||
           (cmd == FPMP_CMD_ERASE) || (cmd == FPMP_CMD_STATUS);
  endfunction : is_cmd

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer and page transfer
  fpmp_state_t              state_reg;
  logic [IDX_W-1:0]         idx_reg;
  logic [ADDR_W-IDX_W-1:0]  base_reg;
  logic [7:0]               page_mem [PAGE_BYTES];
  logic                     pgm_valid_reg;
  logic [ADDR_W-1:0]        pgm_addr_reg;
  logic [7:0]               pgm_data_reg;
  logic                     pgm_commit_reg;
  logic                     erase_start_reg;
  logic                     new_cmd;   // accepted command write; clears result unless 71 or in FPMP_ERASE_ARM/FPMP_STATUS_ARM

  // busy states take no command write at all
  assign new_cmd = wr_evt && is_cmd(data_s) &&
                   (state_reg == FPMP_READ || state_reg == FPMP_STATUS ||
                    state_reg == FPMP_POLL || state_reg == FPMP_ERASE_ARM ||
                    state_reg == FPMP_STATUS_ARM);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg       <= FPMP_READ;
      idx_reg         <= '0;
      base_reg        <= '0;
      pgm_valid_reg   <= 1'b0;
      pgm_addr_reg    <= '0;
      pgm_data_reg    <= FPMP_DATA_RST;
      pgm_commit_reg  <= 1'b0;
      erase_start_reg <= 1'b0;
    end else begin
      pgm_commit_reg  <= 1'b0;
      erase_start_reg <= 1'b0;
      case (state_reg)
        // read, status and polling states take a fresh first cycle
        FPMP_READ, FPMP_STATUS, FPMP_POLL: begin
          if (wr_evt) begin
            state_reg <= cmd_target(data_s, state_reg);
            idx_reg   <= '0;
          end
        end
        // gather 128 address plus data writes
        FPMP_PGM_LOAD: begin
          if (wr_evt) begin
            if (idx_reg == '0) begin
              base_reg <= addr_s[ADDR_W-1:IDX_W];
            end
            idx_reg <= idx_reg + IDX_ONE;
            if (idx_reg == IDX_LAST) begin
              if (prog_allowed) begin
                // hand the whole page over as one operation
                state_reg     <= FPMP_PGM_PUSH;
                pgm_valid_reg <= 1'b1;
                pgm_addr_reg  <= {base_reg, IDX_W'(0)};
                pgm_data_reg  <= page_mem[0];
              end else begin
                state_reg <= FPMP_POLL;
              end
            end
          end
        end
        // stream the page, then commit it in one go
        FPMP_PGM_PUSH: begin
          if (pgm_valid_reg && pgm_ready) begin
            idx_reg <= idx_reg + IDX_ONE;
            if (idx_reg == IDX_LAST) begin
              pgm_valid_reg  <= 1'b0;
              pgm_commit_reg <= 1'b1;
              state_reg      <= FPMP_PGM_WAIT;
            end else begin
              pgm_addr_reg <= {base_reg, idx_reg + IDX_ONE};
              pgm_data_reg <= page_mem[idx_reg + IDX_ONE];
            end
          end
        end
        // second 20 starts the full erase
        FPMP_ERASE_ARM: begin
          if (wr_evt) begin
            if (data_s == FPMP_CMD_ERASE) begin
              if (prog_allowed) begin
                erase_start_reg <= 1'b1;
                state_reg       <= FPMP_ERASE_WAIT;
              end else begin
                state_reg <= FPMP_POLL;
              end
            end else begin
              state_reg <= cmd_target(data_s, state_reg);
              idx_reg   <= '0;
            end
          end
        end
        // second 71 opens the status read
        FPMP_STATUS_ARM: begin
          if (wr_evt) begin
            if (data_s == FPMP_CMD_STATUS) state_reg <= FPMP_STATUS;
            else state_reg <= cmd_target(data_s, state_reg);
            idx_reg <= '0;
          end
        end
        FPMP_PGM_WAIT, FPMP_ERASE_WAIT: begin
          if (op_done) state_reg <= FPMP_POLL;
        end
        default: state_reg <= FPMP_READ;
      endcase
    end
  end

  // page buffer holds data only, so it needs no reset
  always_ff @(posedge sys_clk) begin
    if (state_reg == FPMP_PGM_LOAD && wr_evt) page_mem[idx_reg] <= data_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // result flags; a command write other than 71 from read, status or polling state clears them, never a busy state
  logic end_reg;
  logic ok_reg;
  logic erase_err_reg;
  logic pgm_err_reg;
  logic addr_err_reg;
  logic prot_err_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      end_reg       <= 1'b0;
      ok_reg        <= 1'b0;
      erase_err_reg <= 1'b0;
      pgm_err_reg   <= 1'b0;
      addr_err_reg  <= 1'b0;
      prot_err_reg  <= 1'b0;
    end else if (state_reg == FPMP_PGM_LOAD && wr_evt) begin
      // misaligned page start still programs but flags the error
      if (idx_reg == '0) begin
        addr_err_reg <= (addr_s[7:0] != FPMP_PAGE_LOW_A) &&
                        (addr_s[7:0] != FPMP_PAGE_LOW_B);
      end
      if (idx_reg == IDX_LAST && !prog_allowed) begin
        prot_err_reg <= 1'b1;
        end_reg      <= 1'b1;
      end
    end else if (state_reg == FPMP_ERASE_ARM && wr_evt &&
                 data_s == FPMP_CMD_ERASE && !prog_allowed) begin
      prot_err_reg <= 1'b1;
      end_reg      <= 1'b1;
    end else if ((state_reg == FPMP_PGM_WAIT || state_reg == FPMP_ERASE_WAIT) &&
                 op_done) begin
      // normal completion only with no failure of any kind
      end_reg <= 1'b1;
      ok_reg  <= !op_fail && !(state_reg == FPMP_PGM_WAIT && addr_err_reg);
      if (state_reg == FPMP_PGM_WAIT) pgm_err_reg <= op_fail;
      else erase_err_reg <= op_fail;
    end else if (new_cmd && state_reg != FPMP_ERASE_ARM &&
                 state_reg != FPMP_STATUS_ARM && data_s != FPMP_CMD_STATUS) begin
      // results live until the next command write from read, status or polling state; status read keeps them
      end_reg       <= 1'b0;
      ok_reg        <= 1'b0;
      erase_err_reg <= 1'b0;
      pgm_err_reg   <= 1'b0;
      addr_err_reg  <= 1'b0;
      prot_err_reg  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data source and bus drive
  logic [7:0] poll_byte;
  logic [7:0] detail_byte;
  logic [7:0] data_out_reg;
  logic       data_oe_reg;

  always_comb begin
    poll_byte = 8'h00;
    poll_byte[FPMP_ST_END_BIT] = end_reg;
    poll_byte[FPMP_ST_OK_BIT]  = ok_reg;
    // status read exposes the internal result signals
    detail_byte = poll_byte;
    detail_byte[FPMP_ST_ERASE_BIT] = erase_err_reg;
    detail_byte[FPMP_ST_PGM_BIT]   = pgm_err_reg;
    detail_byte[FPMP_ST_ADDR_BIT]  = addr_err_reg;
    detail_byte[FPMP_ST_PROT_BIT]  = prot_err_reg;
  end

  // what a read returns follows the active mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      data_out_reg <= FPMP_DATA_RST;
    end else begin
      case (state_reg)
        FPMP_READ:   data_out_reg <= flash_rd_data;
        // read after the double 71 gives error detail
        FPMP_STATUS: data_out_reg <= detail_byte;
        // polling byte readable with select and output enable low
        FPMP_PGM_PUSH, FPMP_PGM_WAIT, FPMP_ERASE_WAIT, FPMP_POLL:
                     data_out_reg <= poll_byte;
        default:     data_out_reg <= FPMP_DATA_RST;
      endcase
    end
  end

  // drive only for select low, output enable low, write strobe high
  // deselect floats the bus and masks write strobes; it touches nothing else
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) data_oe_reg <= 1'b0;
    else       data_oe_reg <= ~ce_s & ~oe_s & we_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // array read address, strap check and busy flag
  logic [ADDR_W-1:0] rd_addr_reg;
  logic              strap_ok_reg;
  logic              busy_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_addr_reg  <= '0;
      strap_ok_reg <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      // each read addresses the array at the pins' address
      rd_addr_reg  <= addr_s;
      // report whether the doubling pll strap is present
      strap_ok_reg <= (md_s == FPMP_STRAP_PLLX2);
      busy_reg     <= (state_reg == FPMP_PGM_PUSH) || (state_reg == FPMP_PGM_WAIT) ||
                      (state_reg == FPMP_ERASE_WAIT);
    end
  end

  assign byte_data_bus_out = data_out_reg;
  assign byte_data_bus_oe  = data_oe_reg;
  assign strap_ok          = strap_ok_reg;
  assign op_busy           = busy_reg;
  assign flash_rd_addr     = rd_addr_reg;
  assign pgm_valid         = pgm_valid_reg;
  assign pgm_addr          = pgm_addr_reg;
  assign pgm_data          = pgm_data_reg;
  assign pgm_commit        = pgm_commit_reg;
  assign erase_start       = erase_start_reg;

endmodule : fpmp_port

`default_nettype wire

// ---- testbench/fpmp_port_sva.sv ----
// fpmp_port_sva: port-level timing checks for the programmer byte port.
// assumes it is bound into fpmp_port and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module fpmp_port_sva
  import fpmp_pkg::*;
#(
  parameter int ADDR_W = FPMP_ADDR_W
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rstn,
  // pins
  input wire logic              chip_sel_n,
  input wire logic              out_en_n,
  input wire logic              wr_strobe_n,
  input wire logic [ADDR_W-1:0] byte_address_bus,
  input wire logic              byte_data_bus_oe,
  input wire logic              program_enable_pin,
  input wire logic              flash_protect_pin,
  input wire logic [3:0]        mode_select_pins,
  // flags and array side
  input wire logic              strap_ok,
  input wire logic              op_busy,
  input wire logic [ADDR_W-1:0] flash_rd_addr,
  input wire logic              pgm_valid,
  input wire logic [ADDR_W-1:0] pgm_addr,
  input wire logic [7:0]        pgm_data,
  input wire logic              pgm_ready,
  input wire logic              pgm_commit,
  input wire logic              erase_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////
  // cycles since release; $past must not look into the reset
  logic [2:0] up_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end

  AST_OE_DECODE: assert property (up_reg == 3'h7 |->
    byte_data_bus_oe == $past(!chip_sel_n && !out_en_n && wr_strobe_n, 3))
    else $error("bus drive does not follow the pin decode");
  AST_RD_ADDR: assert property (up_reg == 3'h7 |->
    flash_rd_addr == $past(byte_address_bus, 3))
    else $error("array read address does not follow the pins");
  AST_STRAP_ON: assert property ((mode_select_pins == FPMP_STRAP_PLLX2)[*5] |-> strap_ok)
    else $error("strap flag low with doubling strap");
  AST_STRAP_OFF: assert property ((mode_select_pins != FPMP_STRAP_PLLX2)[*5] |-> !strap_ok)
    else $error("strap flag high without doubling strap");
  AST_PGM_HOLD: assert property (pgm_valid && !pgm_ready |=>
    pgm_valid && $stable(pgm_addr) && $stable(pgm_data))
    else $error("page byte changed while stalled");
  AST_COMMIT_ONE: assert property (pgm_commit |=> !pgm_commit && !pgm_valid)
    else $error("commit not a single pulse");
  AST_ERASE_ONE: assert property (erase_start |=> !erase_start)
    else $error("erase start not a single pulse");
  AST_ERASE_BUSY: assert property (erase_start |-> ##[0:2] op_busy)
    else $error("busy not raised after erase start");
  AST_PROT_GATE: assert property ((!program_enable_pin || !flash_protect_pin)[*6] |->
    !erase_start && !pgm_commit)
    else $error("operation started without program enable");

  COV_ERASE: cover property (erase_start);
  COV_COMMIT: cover property (pgm_commit);
  COV_STALL: cover property (pgm_valid && !pgm_ready);
endmodule : fpmp_port_sva

bind fpmp_port fpmp_port_sva #(.ADDR_W(ADDR_W)) u_sva (.sys_clk, .rstn, .chip_sel_n,
  .out_en_n, .wr_strobe_n, .byte_address_bus, .byte_data_bus_oe, .program_enable_pin,
  .flash_protect_pin, .mode_select_pins, .strap_ok, .op_busy, .flash_rd_addr,
  .pgm_valid, .pgm_addr, .pgm_data, .pgm_ready, .pgm_commit, .erase_start);

`default_nettype wire

// ---- testbench/fpmp_array_model.sv ----
// fpmp_array_model: behavioural flash array behind the port.
// assumes one clock; reads answer a cycle late, ready stalls every 4th cycle.
`timescale 1ns/1ps
`default_nettype none

module fpmp_array_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // array port
  input  wire logic [17:0] flash_rd_addr,
  output logic      [7:0]  flash_rd_data,
  input  wire logic        pgm_valid,
  input  wire logic [17:0] pgm_addr,
  input  wire logic [7:0]  pgm_data,
  output logic             pgm_ready,
  input  wire logic        pgm_commit,
  input  wire logic        erase_start,
  output logic             op_done,
  output logic             op_fail,
  // bench control and record
  input  wire logic        fail_next,
  output logic      [7:0]  page_count,
  output logic      [17:0] last_addr,
  output logic      [7:0]  last_data
);
  logic [1:0] tick_reg;
  logic [7:0] cnt_reg;
  logic [5:0] wait_reg;

  ////////////////////////////////////////////////////////////////
  // contents are a pattern of the address, so no storage is needed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) flash_rd_data <= 8'h00;
    else flash_rd_data <= flash_rd_addr[7:0] ^ 8'h5a;
  end

  // page collect; the stall makes the port hold a byte
  assign pgm_ready = (tick_reg != 2'h3);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_reg <= 2'h0;
      cnt_reg <= 8'h00;
      page_count <= 8'h00;
      last_addr <= 18'h00000;
      last_data <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 2'h1;
      if (pgm_valid && pgm_ready) begin
        cnt_reg <= cnt_reg + 8'h01;
        last_addr <= pgm_addr;
        last_data <= pgm_data;
      end
      if (pgm_commit) begin
        page_count <= cnt_reg;
        cnt_reg <= 8'h00;
      end
    end
  end

  // operation time, then one done pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 6'h00;
      op_done <= 1'b0;
      op_fail <= 1'b0;
    end else begin
      op_done <= (wait_reg == 6'h01);
      op_fail <= (wait_reg == 6'h01) && fail_next;
      if (pgm_commit || erase_start) wait_reg <= 6'h14;
      else if (wait_reg != 6'h00) wait_reg <= wait_reg - 6'h01;
    end
  end
endmodule : fpmp_array_model

`default_nettype wire

// ---- testbench/test_flash_programmer_mode_port.sv ----
// test_flash_programmer_mode_port: pin-level command sequences with expectations.
// assumes fpmp_port, its bound checker and fpmp_array_model.
`timescale 1ns/1ps
`default_nettype none

module test_flash_programmer_mode_port;
  import fpmp_pkg::*;

  logic sys_clk, rstn, chip_sel_n, out_en_n, wr_strobe_n, drv_on;
  logic pe, fp, strap_ok, op_busy, oe, pgm_valid, pgm_ready, pgm_commit;
  logic erase_start, op_done, op_fail, fail_next;
  logic [17:0] addr, rd_addr, pgm_addr, last_addr;
  logic [7:0]  drv_data, data_in, data_out, rd_data, pgm_data, page_count, last_data;
  logic [3:0]  mode;
  int fails, checks_done, cyc;

  // released bus shows the inverse of the last driven byte
  assign data_in = oe ? data_out : (drv_on ? drv_data : ~drv_data);

  fpmp_port DUT (.sys_clk(sys_clk), .rstn(rstn), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .byte_address_bus(addr),
    .byte_data_bus_in(data_in), .byte_data_bus_out(data_out), .byte_data_bus_oe(oe),
    .program_enable_pin(pe), .flash_protect_pin(fp), .mode_select_pins(mode),
    .strap_ok(strap_ok), .op_busy(op_busy), .flash_rd_addr(rd_addr),
    .flash_rd_data(rd_data), .pgm_valid(pgm_valid), .pgm_addr(pgm_addr),
    .pgm_data(pgm_data), .pgm_ready(pgm_ready), .pgm_commit(pgm_commit),
    .erase_start(erase_start), .op_done(op_done), .op_fail(op_fail));

  fpmp_array_model u_array (.sys_clk(sys_clk), .rstn(rstn), .flash_rd_addr(rd_addr),
    .flash_rd_data(rd_data), .pgm_valid(pgm_valid), .pgm_addr(pgm_addr),
    .pgm_data(pgm_data), .pgm_ready(pgm_ready), .pgm_commit(pgm_commit),
    .erase_start(erase_start), .op_done(op_done), .op_fail(op_fail),
    .fail_next(fail_next), .page_count(page_count), .last_addr(last_addr),
    .last_data(last_data));

  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // strobe low and high 4 cycles each, over the 3-cycle minimum
  task automatic pin_write(input logic [17:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    drv_data = d;
    drv_on = 1'b1;
    wr_strobe_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr_strobe_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    drv_on = 1'b0;
  endtask : pin_write

  task automatic pin_read(input logic [17:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(negedge sys_clk);
    addr = a;
    out_en_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check("drive enable", 18'h1, oe);
    check("read byte", exp, data_out & m);
    out_en_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : pin_read

  task automatic cmd2(input logic [7:0] c);
    pin_write(18'h00000, c);
    pin_write(18'h00000, c);
  endtask : cmd2

  // programmer waits out busy before any further command
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(negedge sys_clk);
    while (op_busy !== 1'b0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check("busy ends", 18'h0, op_busy);
  endtask : wait_idle

  // the last 8 bytes stand for unused places
  task automatic program_page(input logic [17:0] base);
    pin_write(18'h00000, FPMP_CMD_PROGRAM);
    for (int i = 0; i < 128; i++) begin
      pin_write(base + 18'(i), (i < 120) ? 8'(i) ^ 8'h33 : 8'hff);
    end
    wait_idle();
    check("page bytes", 18'd128, page_count);
    check("last address", {base[17:7], 7'h7f}, last_addr);
    check("last data", 18'hff, last_data);
  endtask : program_page

  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard, far above the run's few thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    {rstn, chip_sel_n, drv_on, pe, fp, fail_next} = 6'b010000;
    {out_en_n, wr_strobe_n} = 2'b11;
    addr = 18'h00000;
    drv_data = 8'h00;
    mode = FPMP_STRAP_PLLX2;
    fails = 0;
    checks_done = 0;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    chip_sel_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("strap", 18'h1, strap_ok);
    pin_write(18'h3ffff, FPMP_CMD_READ);
    pin_read(18'h00012, 8'h12 ^ 8'h5a, 8'hff);
    pin_read(18'h3ff80, 8'h80 ^ 8'h5a, 8'hff);
    chip_sel_n = 1'b1;
    out_en_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check("chip disable float", 18'h0, oe);
    chip_sel_n = 1'b0;
    out_en_n = 1'b1;
    pin_read(18'h00044, 8'h44 ^ 8'h5a, 8'hff);
    pin_write(18'h00000, 8'h55);
    pin_read(18'h00021, 8'h21 ^ 8'h5a, 8'hff);
    $display("test read mode done");
    {pe, fp} = 2'b11;
    program_page(18'h00100);
    pin_read(18'h00000, 8'hc0, 8'hff);
    pin_write(18'h00000, 8'h55);
    pin_read(18'h00000, 8'hc0, 8'hff);
    program_page(18'h00210);
    pin_read(18'h00000, 8'h80, 8'hff);
    cmd2(FPMP_CMD_STATUS);
    pin_read(18'h00000, 8'h08, 8'h3c);
    $display("test program done");
    fail_next = 1'b1;
    cmd2(FPMP_CMD_ERASE);
    wait_idle();
    pin_read(18'h00000, 8'h80, 8'hff);
    cmd2(FPMP_CMD_STATUS);
    pin_read(18'h00000, 8'h20, 8'h3c);
    fail_next = 1'b0;
    cmd2(FPMP_CMD_ERASE);
    wait_idle();
    pin_read(18'h00000, 8'hc0, 8'hff);
    $display("test erase done");
    fp = 1'b0;
    cmd2(FPMP_CMD_ERASE);
    wait_idle();
    pin_read(18'h00000, 8'h80, 8'hff);
    cmd2(FPMP_CMD_STATUS);
    pin_read(18'h00000, 8'h04, 8'h3c);
    {pe, fp} = 2'b01;
    cmd2(FPMP_CMD_ERASE);
    wait_idle();
    pin_read(18'h00000, 8'h80, 8'hff);
    mode = 4'h0;
    repeat (6) @(negedge sys_clk);
    check("strap off", 18'h0, strap_ok);
    $display("test protect done");
    test_done();
  end
endmodule : test_flash_programmer_mode_port

`default_nettype wire
